// ==== src/ctcr_axi_slave.sv ====
`timescale 1ns/10ps
// ****************************************************************
// AXI4-Lite front end: channel handshakes and response holding.
// ****************************************************************
module ctcr_axi_slave (
  input wire logic mclk_i, // System clock.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic [ctcr_pkg::ADDR_W-1:0] s_axi_awaddr_i, // Write address.
  input wire logic s_axi_awvalid_i, // Write address valid.
  output logic s_axi_awready_o, // Write address ready.
  input wire logic [ctcr_pkg::DATA_W-1:0] s_axi_wdata_i, // Write data.
  input wire logic [3:0] s_axi_wstrb_i, // Write byte strobes.
  input wire logic s_axi_wvalid_i, // Write data valid.
  output logic s_axi_wready_o, // Write data ready.
  output logic [1:0] s_axi_bresp_o, // Write response code.
  output logic s_axi_bvalid_o, // Write response valid.
  input wire logic s_axi_bready_i, // Write response ready.
  input wire logic s_axi_arvalid_i, // Read address valid.
  output logic s_axi_arready_o, // Read address ready.
  output logic [ctcr_pkg::DATA_W-1:0] s_axi_rdata_o, // Read data.
  output logic [1:0] s_axi_rresp_o, // Read response code.
  output logic s_axi_rvalid_o, // Read data valid.
  input wire logic s_axi_rready_i, // Read data ready.
  output logic wr_req_o, // One-cycle write to the bank.
  output logic [ctcr_pkg::ADDR_W-1:0] wr_addr_o, // Held write address.
  output logic [ctcr_pkg::DATA_W-1:0] wr_data_o, // Held write data.
  output logic [3:0] wr_strb_o, // Held write strobes.
  input wire logic wr_ok_i, // Write address is mapped.
  input wire logic [ctcr_pkg::DATA_W-1:0] rd_data_i, // Read word for araddr.
  input wire logic rd_ok_i // Read address is mapped.
);

  // Whole state of the front end.
  typedef struct packed {
    logic aw_held; // Address taken, write not done.
    logic [ctcr_pkg::ADDR_W-1:0] addr; // Taken write address.
    logic w_held; // Data taken, write not done.
    logic [ctcr_pkg::DATA_W-1:0] data; // Taken write data.
    logic [3:0] strb; // Taken strobes.
    logic bvalid; // Write response pending.
    logic [1:0] bresp; // Write response code.
    logic rvalid; // Read response pending.
    logic [ctcr_pkg::DATA_W-1:0] rdata; // Read data.
    logic [1:0] rresp; // Read response code.
  } ctcr_axi_t;

  ctcr_axi_t st_r; // Registered state.
  ctcr_axi_t st_nxt; // Next state.

  // Readiness: a channel stalls while its item or the answer is pending.
  assign s_axi_awready_o = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready_o = !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready_o = !st_r.rvalid;
  // The bank write fires once both halves are in and no answer waits.
  assign wr_req_o = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign wr_addr_o = st_r.addr;
  assign wr_data_o = st_r.data;
  assign wr_strb_o = st_r.strb;
  assign s_axi_bvalid_o = st_r.bvalid;
  assign s_axi_bresp_o = st_r.bresp;
  assign s_axi_rvalid_o = st_r.rvalid;
  assign s_axi_rdata_o = st_r.rdata;
  assign s_axi_rresp_o = st_r.rresp;

  // Next-state logic for both channels.
  always_comb begin
    st_nxt = st_r;
    // Address and data may arrive in either order.
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      st_nxt.w_held = 1'b1;
      st_nxt.data = s_axi_wdata_i;
      st_nxt.strb = s_axi_wstrb_i;
    end
    // The write lands in the bank this cycle; answer next.
    if (wr_req_o) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_ok_i ? ctcr_pkg::RESP_OKAY : ctcr_pkg::RESP_SLVERR;
    end else if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid = 1'b0;
    end
    // Reads are answered from the word decoded for the presented address.
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_data_i;
      st_nxt.rresp = rd_ok_i ? ctcr_pkg::RESP_OKAY : ctcr_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : ctcr_axi_slave

// ==== src/ctcr_pkg.sv ====
// ****************************************************************
// Shared constants of the cycle timing configuration bank.
// ****************************************************************
package ctcr_pkg;

  // Bus geometry: byte address width, data width, stored word width.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // Register index sits above the two byte-select bits.
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_SSC = 8'h8e; // static_slot_count
  localparam logic [7:0] IDX_SPW = 8'h90; // static_payload_words
  localparam logic [7:0] IDX_NML = 8'hac; // nominal_macrotick_length
  localparam logic [7:0] IDX_SSL = 8'hb0; // static_slot_length
  localparam logic [7:0] IDX_MPC = 8'hb2; // macroticks_per_cycle
  localparam logic [7:0] IDX_CUL = 8'hb4; // cycle_microticks_low
  localparam logic [7:0] IDX_CUH = 8'hb6; // cycle_microticks_high
  localparam logic [7:0] IDX_SFL = 8'hc2; // sync_frame_limit
  localparam logic [7:0] IDX_MSL = 8'hc6; // minislot_length
  localparam logic [7:0] IDX_MAO = 8'hc8; // minislot_action_offset
  localparam logic [7:0] IDX_SAO = 8'hca; // slot_action_offset
  localparam logic [7:0] IDX_CTRL = 8'h80; // protocol_control

  // Storage slots inside the bank; SL_NONE marks an unmapped index.
  localparam int NUM_SLOTS = 11;
  localparam logic [3:0] SL_SSC = 4'h0;
  localparam logic [3:0] SL_SPW = 4'h1;
  localparam logic [3:0] SL_NML = 4'h2;
  localparam logic [3:0] SL_SSL = 4'h3;
  localparam logic [3:0] SL_MPC = 4'h4;
  localparam logic [3:0] SL_CUL = 4'h5;
  localparam logic [3:0] SL_CUH = 4'h6;
  localparam logic [3:0] SL_SFL = 4'h7;
  localparam logic [3:0] SL_MSL = 4'h8;
  localparam logic [3:0] SL_MAO = 4'h9;
  localparam logic [3:0] SL_SAO = 4'ha;
  localparam logic [3:0] SL_NONE = 4'hf;

  // Implemented field widths; all higher bits are reserved.
  localparam int W_SSC = 11;
  localparam int W_SPW = 7;
  localparam int W_NML = 8;
  localparam int W_SSL = 8;
  localparam int W_MPC = 14;
  localparam int W_CUL = 16;
  localparam int W_CUH = 8;
  localparam int W_SFL = 16;
  localparam int W_MSL = 7;
  localparam int W_MAO = 4;
  localparam int W_SAO = 4;

  // Reset values; fields without a defined reset start at zero.
  localparam logic [15:0] RST_SSC = 16'h0001;
  localparam logic [15:0] RST_SPW = 16'h0000;
  localparam logic [15:0] RST_UNDEF = 16'h0000;
  localparam logic [NUM_SLOTS-1:0][15:0] RST_REGS = {
    RST_UNDEF, RST_UNDEF, RST_UNDEF, RST_UNDEF, RST_UNDEF, RST_UNDEF,
    RST_UNDEF, RST_UNDEF, RST_UNDEF, RST_SPW, RST_SSC};

  // Control register fields.
  localparam int CTRL_CFG_BIT = 0;
  localparam int CTRL_REFUSED_BIT = 1;
  localparam logic CTRL_RST_CFG = 1'b1;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ctcr_pkg

// ==== src/ctcr_regs.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Cycle timing configuration register bank.
// ****************************************************************

// Behaviour
// - Sync frame limit stored, host programs 2..15.
// - Timing writes only accepted in configuration state.
// - Microticks per cycle split high and low.
// - Static slot length in low eight bits.
// - Slot count eleven bits, resets to one.
// - Static payload seven bits, resets to zero.
// - Minislot action offset four bits, 1..15.
// - Static action offset four bits, 1..15.
// - Macroticks per cycle held for startup use.
module ctcr_regs (
  input wire logic mclk_i, // System clock, 50 MHz.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic [ctcr_pkg::ADDR_W-1:0] s_axi_awaddr_i, // Write address.
  input wire logic s_axi_awvalid_i, // Write address valid.
  output logic s_axi_awready_o, // Write address ready.
  input wire logic [ctcr_pkg::DATA_W-1:0] s_axi_wdata_i, // Write data.
  input wire logic [3:0] s_axi_wstrb_i, // Write byte strobes.
  input wire logic s_axi_wvalid_i, // Write data valid.
  output logic s_axi_wready_o, // Write data ready.
  output logic [1:0] s_axi_bresp_o, // Write response code.
  output logic s_axi_bvalid_o, // Write response valid.
  input wire logic s_axi_bready_i, // Write response ready.
  input wire logic [ctcr_pkg::ADDR_W-1:0] s_axi_araddr_i, // Read address.
  input wire logic s_axi_arvalid_i, // Read address valid.
  output logic s_axi_arready_o, // Read address ready.
  output logic [ctcr_pkg::DATA_W-1:0] s_axi_rdata_o, // Read data.
  output logic [1:0] s_axi_rresp_o, // Read response code.
  output logic s_axi_rvalid_o, // Read data valid.
  input wire logic s_axi_rready_i, // Read data ready.
  output logic config_state_o, // Controller in configuration state.
  output logic [ctcr_pkg::W_SFL-1:0] sync_frame_limit_o, // Sync frame limit.
  output logic [ctcr_pkg::W_NML-1:0] nominal_macrotick_length_o, // uT per MT.
  output logic [ctcr_pkg::W_CUH+ctcr_pkg::W_CUL-1:0] cycle_microticks_o, // Split uT.
  output logic [ctcr_pkg::W_SSL-1:0] static_slot_length_o, // MT per slot.
  output logic [ctcr_pkg::W_SSC-1:0] static_slot_count_o, // Static slots.
  output logic [ctcr_pkg::W_SPW-1:0] static_payload_words_o, // Payload words.
  output logic [ctcr_pkg::W_MSL-1:0] minislot_length_o, // Minislot MT.
  output logic [ctcr_pkg::W_MAO-1:0] minislot_action_offset_o, // Minislot AP.
  output logic [ctcr_pkg::W_SAO-1:0] slot_action_offset_o, // Static AP.
  output logic [ctcr_pkg::W_MPC-1:0] macroticks_per_cycle_o // MT per cycle.
);

  // ****************************************************************
  // State and helpers.
  // ****************************************************************

  // Whole state of the bank.
  typedef struct packed {
    logic cfg; // Configuration state; unlocks the timing registers.
    logic refused; // Sticky: a timing write came outside configuration.
    logic [ctcr_pkg::NUM_SLOTS-1:0][ctcr_pkg::REG_W-1:0] regs; // Stored values.
  } ctcr_state_t;

  // The bank leaves reset in configuration with the documented values.
  localparam ctcr_state_t ST_RST = '{
    cfg: ctcr_pkg::CTRL_RST_CFG,
    refused: 1'b0,
    regs: ctcr_pkg::RST_REGS};

  ctcr_state_t st_r; // Registered state.
  ctcr_state_t st_nxt; // Next state.

  logic wr_req; // One-cycle write from the front end.
  logic [ctcr_pkg::ADDR_W-1:0] wr_addr; // Write address.
  logic [ctcr_pkg::DATA_W-1:0] wr_data; // Write data.
  logic [3:0] wr_strb; // Write strobes.
  logic [3:0] wr_slot; // Slot addressed by the write.
  logic [3:0] rd_slot; // Slot addressed by the read.
  logic wr_ctrl; // Write hits the control register.
  logic rd_ctrl; // Read hits the control register.
  logic wr_ok; // Write address mapped.
  logic rd_ok; // Read address mapped.
  logic [ctcr_pkg::DATA_W-1:0] rd_data; // Decoded read word.

  // Maps a byte address to a slot; misaligned or unlisted indices are unmapped, bits 11:10 are ignored.
  function automatic logic [3:0] slot_of(input logic [ctcr_pkg::ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[ctcr_pkg::IDX_LSB +: ctcr_pkg::IDX_W];
    if (a[ctcr_pkg::IDX_LSB-1:0] != 2'b00) begin
      slot_of = ctcr_pkg::SL_NONE;
    end else begin
      case (idx)
        ctcr_pkg::IDX_SSC: slot_of = ctcr_pkg::SL_SSC;
        ctcr_pkg::IDX_SPW: slot_of = ctcr_pkg::SL_SPW;
        ctcr_pkg::IDX_NML: slot_of = ctcr_pkg::SL_NML;
        ctcr_pkg::IDX_SSL: slot_of = ctcr_pkg::SL_SSL;
        ctcr_pkg::IDX_MPC: slot_of = ctcr_pkg::SL_MPC;
        ctcr_pkg::IDX_CUL: slot_of = ctcr_pkg::SL_CUL;
        ctcr_pkg::IDX_CUH: slot_of = ctcr_pkg::SL_CUH;
        ctcr_pkg::IDX_SFL: slot_of = ctcr_pkg::SL_SFL;
        ctcr_pkg::IDX_MSL: slot_of = ctcr_pkg::SL_MSL;
        ctcr_pkg::IDX_MAO: slot_of = ctcr_pkg::SL_MAO;
        ctcr_pkg::IDX_SAO: slot_of = ctcr_pkg::SL_SAO;
        default: slot_of = ctcr_pkg::SL_NONE;
      endcase
    end
  endfunction : slot_of

  // The control word sits outside the timing slots, so it is never locked.
  // Tells whether a byte address is the aligned control register.
  function automatic logic is_ctrl(input logic [ctcr_pkg::ADDR_W-1:0] a);
    is_ctrl = (a[ctcr_pkg::IDX_LSB-1:0] == 2'b00) &&
      (a[ctcr_pkg::IDX_LSB +: ctcr_pkg::IDX_W] == ctcr_pkg::IDX_CTRL);
  endfunction : is_ctrl

  // Mask of implemented bits per slot; reserved bits are never stored.
  // Masking at store time keeps reserved bits zero on every read path.
  function automatic logic [15:0] mask_of(input logic [3:0] s);
    case (s)
      ctcr_pkg::SL_SSC: mask_of = 16'((1 << ctcr_pkg::W_SSC) - 1);
      ctcr_pkg::SL_SPW: mask_of = 16'((1 << ctcr_pkg::W_SPW) - 1);
      ctcr_pkg::SL_NML: mask_of = 16'((1 << ctcr_pkg::W_NML) - 1);
      ctcr_pkg::SL_SSL: mask_of = 16'((1 << ctcr_pkg::W_SSL) - 1);
      ctcr_pkg::SL_MPC: mask_of = 16'((1 << ctcr_pkg::W_MPC) - 1);
      ctcr_pkg::SL_CUL: mask_of = 16'((1 << ctcr_pkg::W_CUL) - 1);
      ctcr_pkg::SL_CUH: mask_of = 16'((1 << ctcr_pkg::W_CUH) - 1);
      ctcr_pkg::SL_SFL: mask_of = 16'((1 << ctcr_pkg::W_SFL) - 1);
      ctcr_pkg::SL_MSL: mask_of = 16'((1 << ctcr_pkg::W_MSL) - 1);
      ctcr_pkg::SL_MAO: mask_of = 16'((1 << ctcr_pkg::W_MAO) - 1);
      ctcr_pkg::SL_SAO: mask_of = 16'((1 << ctcr_pkg::W_SAO) - 1);
      default: mask_of = 16'h0000;
    endcase
  endfunction : mask_of

  // ****************************************************************
  // Bus front end.
  // ****************************************************************

  // Handshakes live in the front end; the bank only sees one-cycle writes.
  ctcr_axi_slave u_axi (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .wr_req_o(wr_req),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_ok_i(wr_ok),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // Address decode for both directions.
  assign wr_slot = slot_of(wr_addr);
  assign rd_slot = slot_of(s_axi_araddr_i);
  assign wr_ctrl = is_ctrl(wr_addr);
  assign rd_ctrl = is_ctrl(s_axi_araddr_i);
  assign wr_ok = wr_ctrl || (wr_slot != ctcr_pkg::SL_NONE);
  assign rd_ok = rd_ctrl || (rd_slot != ctcr_pkg::SL_NONE);

  // Read word: stored values sit in the low half, unmapped reads zero.
  // The front end latches this word at the address handshake, so the decode
  // must settle from the presented address within that same cycle.
  always_comb begin
    rd_data = '0;
    if (rd_ctrl) begin
      rd_data[ctcr_pkg::CTRL_CFG_BIT] = st_r.cfg;
      rd_data[ctcr_pkg::CTRL_REFUSED_BIT] = st_r.refused;
    end else if (rd_slot != ctcr_pkg::SL_NONE) begin
      rd_data[ctcr_pkg::REG_W-1:0] = st_r.regs[rd_slot];
    end
  end

  // ****************************************************************
  // Register bank.
  // ****************************************************************

  // Next-state logic: control writes, gated timing writes, refusal flag.
  always_comb begin
    logic [15:0] lane;
    logic [15:0] keep;
    lane = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    keep = '0;
    st_nxt = st_r;
    if (wr_req && wr_ctrl && wr_strb[0]) begin
      // The control byte is always writable; it opens and closes the bank.
      st_nxt.cfg = wr_data[ctcr_pkg::CTRL_CFG_BIT];
      // Writing one clears the refusal flag.
      if (wr_data[ctcr_pkg::CTRL_REFUSED_BIT]) begin
        st_nxt.refused = 1'b0;
      end
    end
    if (wr_req && (wr_slot != ctcr_pkg::SL_NONE)) begin
      if (st_r.cfg) begin
        // Merge by byte lane; reserved bits stay zero.
        keep = mask_of(wr_slot) & lane;
        st_nxt.regs[wr_slot] = (st_r.regs[wr_slot] & ~keep) |
          (wr_data[15:0] & keep);
      end else begin
        // A locked write still answers OKAY; software reads the flag to notice it.
        // Outside configuration the value is kept; the set wins a clear.
        st_nxt.refused = 1'b1;
      end
    end
  end

  // State register; constant reset only.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Parameter outputs to the protocol engine.
  // ****************************************************************

  // Every field is driven straight from its flip-flops.
  assign config_state_o = st_r.cfg;
  assign sync_frame_limit_o = st_r.regs[ctcr_pkg::SL_SFL][ctcr_pkg::W_SFL-1:0];
  assign nominal_macrotick_length_o = st_r.regs[ctcr_pkg::SL_NML][ctcr_pkg::W_NML-1:0];
  // High part above the low part, as one microtick count.
  assign cycle_microticks_o = {st_r.regs[ctcr_pkg::SL_CUH][ctcr_pkg::W_CUH-1:0],
    st_r.regs[ctcr_pkg::SL_CUL][ctcr_pkg::W_CUL-1:0]};
  assign static_slot_length_o = st_r.regs[ctcr_pkg::SL_SSL][ctcr_pkg::W_SSL-1:0];
  assign static_slot_count_o = st_r.regs[ctcr_pkg::SL_SSC][ctcr_pkg::W_SSC-1:0];
  assign static_payload_words_o = st_r.regs[ctcr_pkg::SL_SPW][ctcr_pkg::W_SPW-1:0];
  assign minislot_length_o = st_r.regs[ctcr_pkg::SL_MSL][ctcr_pkg::W_MSL-1:0];
  assign minislot_action_offset_o = st_r.regs[ctcr_pkg::SL_MAO][ctcr_pkg::W_MAO-1:0];
  assign slot_action_offset_o = st_r.regs[ctcr_pkg::SL_SAO][ctcr_pkg::W_SAO-1:0];
  // Only read by startup logic; frozen once configuration is left.
  assign macroticks_per_cycle_o = st_r.regs[ctcr_pkg::SL_MPC][ctcr_pkg::W_MPC-1:0];

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // A full-word write in configuration lands in the sync frame limit.
  sync_limit_store_a: assert property (
    wr_req && st_r.cfg && wr_slot == ctcr_pkg::SL_SFL && wr_strb[1:0] == 2'b11
    |=> sync_frame_limit_o == $past(wr_data[15:0]))
    else $error("sync frame limit not stored");

  // A timing write outside configuration changes no value and raises the flag.
  locked_write_a: assert property (
    wr_req && !st_r.cfg && wr_slot != ctcr_pkg::SL_NONE
    |=> $stable(st_r.regs) && st_r.refused)
    else $error("locked write altered the bank");

  // Writing the low part leaves the high part alone.
  split_low_a: assert property (
    wr_req && st_r.cfg && wr_slot == ctcr_pkg::SL_CUL && wr_strb[1:0] == 2'b11
    |=> $stable(cycle_microticks_o[23:16])
      && cycle_microticks_o[15:0] == $past(wr_data[15:0]))
    else $error("microtick split write wrong");

  // A static slot length read shows nothing above the low byte.
  slot_len_read_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o && rd_slot == ctcr_pkg::SL_SSL
    |=> s_axi_rvalid_o && (s_axi_rdata_o >> ctcr_pkg::W_SSL) == '0
      && s_axi_rdata_o[7:0] == static_slot_length_o)
    else $error("static slot length read wrong");

  // The slot count comes out of reset at one.
  slot_count_rst_a: assert property (
    $rose(reset_n_i) |-> static_slot_count_o == 11'h001)
    else $error("static slot count reset wrong");

  // The payload count comes out of reset at zero and keeps seven bits.
  payload_rst_a: assert property (
    $rose(reset_n_i) |-> static_payload_words_o == 7'h00
      ##1 (st_r.regs[ctcr_pkg::SL_SPW] >> ctcr_pkg::W_SPW) == '0)
    else $error("static payload reset wrong");

  // A configuration write to the minislot offset keeps only four bits.
  mslot_offset_a: assert property (
    wr_req && st_r.cfg && wr_slot == ctcr_pkg::SL_MAO && wr_strb[0]
    |=> minislot_action_offset_o == $past(wr_data[3:0])
      && st_r.regs[ctcr_pkg::SL_MAO][15:4] == 12'h000)
    else $error("minislot offset store wrong");

  // A static action offset read returns the stored nibble only.
  slot_offset_read_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o && rd_slot == ctcr_pkg::SL_SAO
    |=> s_axi_rdata_o == {28'h0000000, slot_action_offset_o})
    else $error("static offset read wrong");

  // The startup cycle length cannot move outside configuration.
  mt_cycle_hold_a: assert property (
    !st_r.cfg |=> $stable(macroticks_per_cycle_o))
    else $error("cycle length moved outside configuration");

  // Unmapped reads answer zero with an error code.
  unmapped_read_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o && !rd_ok
    |=> s_axi_rvalid_o && s_axi_rdata_o == '0
      && s_axi_rresp_o == ctcr_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");

  // An unmapped write is answered with an error code.
  unmapped_write_a: assert property (
    wr_req && !wr_ok |=> s_axi_bvalid_o && s_axi_bresp_o == ctcr_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

  // Writing one to the refusal bit clears the sticky flag.
  refused_clear_a: assert property (
    wr_req && wr_ctrl && wr_strb[0] && wr_data[ctcr_pkg::CTRL_REFUSED_BIT]
    |=> !st_r.refused)
    else $error("refusal flag not cleared");

  // A low-lane write to the sync frame limit keeps its high byte.
  sync_limit_lane_a: assert property (
    wr_req && st_r.cfg && wr_slot == ctcr_pkg::SL_SFL && wr_strb[1:0] == 2'b01
    |=> $stable(sync_frame_limit_o[15:8]))
    else $error("sync frame limit high byte moved");

endmodule : ctcr_regs

// ==== test/ctcr_host_model.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Host side: a plain AXI4-Lite master used by the bench.
// ****************************************************************
// Ports carry the names of the bank's ports so that one wildcard connects both.
module ctcr_host_model (
  input wire logic mclk_i, // Clock.
  output logic [11:0] s_axi_awaddr_i, // Write address.
  output logic s_axi_awvalid_i, // Address valid.
  input wire logic s_axi_awready_o, // Address ready.
  output logic [31:0] s_axi_wdata_i, // Write data.
  output logic s_axi_wvalid_i, // Data valid.
  input wire logic s_axi_wready_o, // Data ready.
  input wire logic [1:0] s_axi_bresp_o, // Write code.
  input wire logic s_axi_bvalid_o, // Write answer.
  output logic s_axi_bready_i, // Write answer ready.
  output logic [11:0] s_axi_araddr_i, // Read address.
  output logic s_axi_arvalid_i, // Read valid.
  input wire logic s_axi_arready_o, // Read ready.
  input wire logic [31:0] s_axi_rdata_o, // Read data.
  input wire logic [1:0] s_axi_rresp_o, // Read code.
  input wire logic s_axi_rvalid_o, // Read answer.
  output logic s_axi_rready_i // Read answer ready.
);
  // Everything idle at time zero.
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = '0;
  end
  // Each task takes its answer at the rising edge at which it stands high.
  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask : wr
  // Read holds rready until the answer is seen.
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask : rd
endmodule : ctcr_host_model

// ==== test/cycle_timing_config_regs_tb_top.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Register bank bench: reset values, widths, lock, unmapped.
// ****************************************************************
module cycle_timing_config_regs_tb_top;
  logic mclk_i = 1'b0; // 50 MHz clock.
  logic reset_n_i = 1'b0; // Held low at start.
  logic [3:0] s_axi_wstrb_i = 4'hf; // Whole words, except one low-byte write in the lock test.
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i; // Addresses.
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd; // Data words.
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs; // Codes.
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o; // Write flow.
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o; // Flow.
  logic s_axi_rvalid_o, s_axi_rready_i, config_state_o; // Read flow, state.
  logic [15:0] sync_frame_limit_o; // Fields.
  logic [23:0] cycle_microticks_o; // Split count.
  logic [13:0] macroticks_per_cycle_o; // Cycle length.
  logic [10:0] static_slot_count_o; // Slots.
  logic [7:0] nominal_macrotick_length_o, static_slot_length_o; // Fields.
  logic [6:0] static_payload_words_o, minislot_length_o; // Fields.
  logic [3:0] minislot_action_offset_o, slot_action_offset_o; // Offsets.
  int n_fail = 0, n_compared = 0; // Counters.
  // Register indices, legal words with reserved bits set, read-back values.
  logic [7:0] idx [11] = '{8'h8e, 8'h90, 8'hac, 8'hb0, 8'hb2, 8'hb4, 8'hb6, 8'hc2, 8'hc6,
    8'hc8, 8'hca};
  logic [15:0] wv [11] = '{16'hfbff, 16'hffff, 16'hff28, 16'hffff, 16'hd000, 16'h7000,
    16'hff02, 16'h000f, 16'hffbf, 16'hffff, 16'hfff1};
  logic [15:0] ev [11] = '{16'h3ff, 16'h7f, 16'h28, 16'hff, 16'h1000, 16'h7000, 16'h2,
    16'hf, 16'h3f, 16'hf, 16'h1};
  always #10 mclk_i = ~mclk_i;
  ctcr_regs u_dut (.*);
  ctcr_host_model u_host (.*);
  // Compares one value.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then stops.
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Main sequence; every register is programmed while configuring.
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    chk(config_state_o, 1);
    for (int i = 0; i < 11; i++) begin
      u_host.rd({2'b0, idx[i], 2'b0}, rd, rs);
      chk(rd, (i == 0) ? 1 : 0);
    end
    $display("reset test done");
    for (int i = 0; i < 11; i++) begin
      u_host.wr({2'b0, idx[i], 2'b0}, {16'hffff, wv[i]}, rs);
      u_host.rd({2'b0, idx[i], 2'b0}, rd, rs);
      chk(rd, ev[i]);
    end
    chk(cycle_microticks_o, 24'h027000);
    chk({nominal_macrotick_length_o, static_slot_length_o}, 16'h28ff);
    chk(macroticks_per_cycle_o, 14'h1000);
    chk({minislot_action_offset_o, slot_action_offset_o}, 8'hf1);
    chk({static_slot_count_o, static_payload_words_o, minislot_length_o},
      {11'h3ff, 7'h7f, 7'h3f});
    $display("width test done");
    u_host.wr(12'h200, 32'h0, rs);
    chk(config_state_o, 0);
    for (int i = 0; i < 11; i++) begin
      u_host.wr({2'b0, idx[i], 2'b0}, 32'h0, rs);
      chk(rs, 2'b00);
      u_host.rd({2'b0, idx[i], 2'b0}, rd, rs);
      chk(rd, ev[i]);
    end
    chk(sync_frame_limit_o, 16'h000f);
    u_host.rd(12'h200, rd, rs);
    chk(rd, 32'h2);
    u_host.wr(12'h200, 32'h3, rs);
    u_host.rd(12'h200, rd, rs);
    chk(rd, 32'h1);
    s_axi_wstrb_i <= 4'h1;
    u_host.wr({2'b0, idx[7], 2'b0}, 32'h0502, rs);
    s_axi_wstrb_i <= 4'hf;
    chk(sync_frame_limit_o, 16'h0002);
    $display("lock test done");
    u_host.wr(12'h004, 32'h1, rs);
    chk(rs, 2'b10);
    u_host.rd(12'h004, rd, rs);
    chk(rd, 32'h0);
    chk(rs, 2'b10);
    $display("unmapped test done");
    give_verdict();
  end
  // Cuts a hang short after 5000 cycles.
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule : cycle_timing_config_regs_tb_top
